// ===== src/hspc_pkg.sv
`default_nettype none
package hspc_pkg;
    // ==========================================================================
    // Timing
    localparam int CLK_PERIOD_NS      = 100;
    localparam int CE_FILTER_NS       = 187_500;
    // Least time, so round up
    localparam int CE_FILTER_CYCLES   = (CE_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CARRY_SHORT_MS     = 5;
    localparam int CARRY_LONG_MS      = 100;
    localparam int CARRY_SHORT_CYCLES = CARRY_SHORT_MS * (1_000_000 / CLK_PERIOD_NS);
    localparam int CARRY_LONG_CYCLES  = CARRY_LONG_MS * (1_000_000 / CLK_PERIOD_NS);

    // ==========================================================================
    // Instruction operands
    localparam int       HALT_KEY_BIT  = 0;
    localparam int       HALT_TMR_BIT  = 1;
    localparam int       HALT_INT_BIT  = 3;
    localparam bit [3:0] HALT_OP_KEY   = 4'h1;
    localparam bit [3:0] HALT_OP_TIMER = 4'h2;
    localparam bit [3:0] HALT_OP_INT   = 4'h8;
    localparam bit [3:0] STOP_OP       = 4'h0;

    // ==========================================================================
    // Interrupt sources, index 0 has the highest priority
    localparam int        NUM_SRC    = 4;
    localparam int        SRC_PIN    = 0;
    localparam int        SRC_TIMER  = 1;
    localparam int        SRC_VSYNC  = 2;
    localparam int        SRC_SERIAL = 3;
    localparam bit [13:0] VEC_RESET  = 14'h0000;
    localparam bit [13:0] VEC_TIMER  = 14'h0003;
    localparam bit [13:0] VEC_PIN    = 14'h0004;
    localparam bit [13:0] VEC_VSYNC  = 14'h0002;
    localparam bit [13:0] VEC_SERIAL = 14'h0001;

    // ==========================================================================
    // Register map, byte addresses
    localparam bit [11:0] REG_IDX_CARRY = 12'h017;
    localparam bit [11:0] ADDR_CTRL     = 12'h000;
    localparam bit [11:0] ADDR_PERMIT   = 12'h004;
    localparam bit [11:0] ADDR_STATUS   = 12'h008;
    localparam bit [11:0] ADDR_CARRY    = 12'(REG_IDX_CARRY * 4);
    localparam int        CTRL_PERIOD_BIT = 0;
    localparam int        CTRL_GIE_BIT    = 1;
    localparam int        CARRY_BIT       = 0;
    localparam int        ST_HALTED_BIT   = 0;
    localparam int        ST_STOPPED_BIT  = 1;
    localparam int        ST_CE_BIT       = 2;
    localparam int        ST_CEPEND_BIT   = 3;
    localparam int        ST_PFD_BIT      = 4;
    localparam int        ST_INSVC_BIT    = 5;
    localparam bit [3:0]  PERMIT_RST      = 4'h0;
endpackage
`default_nettype wire

// ===== src/hspc_aux_if.sv
`timescale 1ns/1ps
`default_nettype none
interface hspc_aux_if;
    logic run;
    logic period_sel;
    logic carry_evt;
    logic ce_raw;
    logic ce_level;
    logic ce_rise;
    modport tmr  (input run, input period_sel, output carry_evt);
    modport filt (input ce_raw, output ce_level, output ce_rise);
    modport core (output run, output period_sel, output ce_raw,
                  input carry_evt, input ce_level, input ce_rise);
endinterface
`default_nettype wire

// ===== src/hspc_carry_timer.sv
`timescale 1ns/1ps
`default_nettype none
module hspc_carry_timer #(
    parameter int SHORT_CYC = hspc_pkg::CARRY_SHORT_CYCLES,
    parameter int LONG_CYC  = hspc_pkg::CARRY_LONG_CYCLES
) (
    input  wire logic   clk_in,
    input  wire logic   rstn_in,
    hspc_aux_if.tmr     aux
);
    localparam int CW = $clog2(LONG_CYC + 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic          evt;
    } hspc_tmr_st_t;

    hspc_tmr_st_t st_ff;
    hspc_tmr_st_t nxt_st;

    // ==========================================================================
    // Period counter, held at zero while the oscillator is stopped
    always_comb begin
        logic [CW-1:0] limit;
        limit  = aux.period_sel ? CW'(SHORT_CYC - 1) : CW'(LONG_CYC - 1);
        nxt_st = st_ff;
        nxt_st.evt = 1'b0;
        if (!aux.run) begin
            nxt_st.cnt = '0;
        end else if (st_ff.cnt >= limit) begin
            nxt_st.cnt = '0;
            nxt_st.evt = 1'b1;
        end else begin
            nxt_st.cnt = st_ff.cnt + CW'(1);
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign aux.carry_evt = st_ff.evt;
endmodule // hspc_carry_timer
`default_nettype wire

// ===== src/hspc_ce_filter.sv
`timescale 1ns/1ps
`default_nettype none
module hspc_ce_filter #(
    parameter int FILT_CYC = hspc_pkg::CE_FILTER_CYCLES
) (
    input  wire logic   clk_in,
    input  wire logic   rstn_in,
    hspc_aux_if.filt    aux
);
    localparam int CW = $clog2(FILT_CYC + 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic          level;
        logic          rise;
    } hspc_filt_st_t;

    hspc_filt_st_t st_ff;
    hspc_filt_st_t nxt_st;

    // ==========================================================================
    // Level must differ for the whole window before it is believed
    always_comb begin
        nxt_st = st_ff;
        nxt_st.rise = 1'b0;
        if (aux.ce_raw == st_ff.level) begin
            nxt_st.cnt = '0;
        end else if (st_ff.cnt >= CW'(FILT_CYC - 1)) begin
            nxt_st.cnt   = '0;
            nxt_st.level = aux.ce_raw;
            nxt_st.rise  = aux.ce_raw;
        end else begin
            nxt_st.cnt = st_ff.cnt + CW'(1);
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign aux.ce_level = st_ff.level;
    assign aux.ce_rise  = st_ff.rise;
endmodule // hspc_ce_filter
`default_nettype wire

// ===== src/hspc_top.sv
// What this block does
// - Halt operand 0010B makes the timer carry flag the wake condition.
// - Timer wake leaves halt in the same step the carry flag sets.
// - Timer carry flag reads as bit 0 of register index 17H.
// - Carry flag sets every 5 ms or 100 ms, software selected.
// - Halt operand 1000B makes interrupt acceptance the wake condition.
// - Interrupt wake ends halt on acceptance, not on a raised request.
// - Pin, timer, vertical sync and serial interrupts can all wake the core.
// - A request is accepted only with global enable and its permit set.
// - With interrupts disabled a raised request leaves the core halted.
// - Accepted interrupt jumps to its vector; return resumes after the halt.
// - Timer vector 0003H, pin vector 0004H, reset starts at 0000H.
// - Pin beats timer; pending timer is taken after the return once global enable is set again.
// - Clock stop instruction stops the crystal oscillator.
// - Clock stop works only with chip enable low, else a no-operation.
// - In clock stop the core and the carry timer cease; the chip enable filter keeps running.
// - Power-failure detector is off during clock stop.
// - Clock stop ends on chip enable rising or on power-on reset.
// - Power-on reset out of clock stop re-enables the failure detector.
// - With chip enable high, its reset applies at the next carry set.
// - Halt ends when any selected condition is met; execution continues.
// - Halt operand 0001B wakes on a high level at any key pin.
// - Power-on or chip enable reset always ends halt and resets.
// - Chip enable ignores levels shorter than 187.5 microseconds.
`timescale 1ns/1ps
`default_nettype none
module hspc_top #(
    parameter int CARRY_SHORT_CYC = hspc_pkg::CARRY_SHORT_CYCLES,
    parameter int CARRY_LONG_CYC  = hspc_pkg::CARRY_LONG_CYCLES,
    parameter int CE_FILT_CYC     = hspc_pkg::CE_FILTER_CYCLES
) (
    input  wire logic        clk_in,
    input  wire logic        rstn_in,
    input  wire logic [11:0] paddr_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [31:0] pwdata_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    input  wire logic        instr_valid_in,
    input  wire logic        instr_halt_in,
    input  wire logic        instr_stop_in,
    input  wire logic [3:0]  operand_in,
    input  wire logic        boundary_in,
    input  wire logic        global_interrupt_enable_instr_in,
    input  wire logic        return_from_interrupt_in,
    input  wire logic [3:0]  irq_in,
    input  wire logic [3:0]  key_entry_pins_in,
    input  wire logic        ce_pin_in,
    input  wire logic        por_in,
    output logic             halted_out,
    output logic             stopped_out,
    output logic             osc_enable_out,
    output logic             pfd_enable_out,
    output logic             stop_nop_out,
    output logic      [3:0]  int_ack_out,
    output logic             vector_valid_out,
    output logic      [13:0] vector_addr_out,
    output logic             core_reset_out
);
    typedef struct packed {
        logic        halted;
        logic [3:0]  hop;
        logic        stopped;
        logic        gie;
        logic        in_service;
        logic [3:0]  permit;
        logic        period_sel;
        logic        carry_flag;
        logic        ce_pend;
        logic        pfd_en;
        logic [3:0]  ack;
        logic        vec_valid;
        logic [13:0] vec;
        logic        nop;
        logic        core_rst;
        logic [31:0] prdata;
    } hspc_top_st_t;

    localparam hspc_top_st_t ST_RST = '{pfd_en: 1'b1, permit: hspc_pkg::PERMIT_RST,
                                        default: '0};

    hspc_top_st_t st_ff;
    hspc_top_st_t nxt_st;
    hspc_aux_if   aux ();

    // ==========================================================================
    // Helpers
    hspc_carry_timer #(
        .SHORT_CYC (CARRY_SHORT_CYC),
        .LONG_CYC  (CARRY_LONG_CYC)
    ) u_timer (
        .clk_in  (clk_in),
        .rstn_in (rstn_in),
        .aux     (aux.tmr)
    );

    hspc_ce_filter #(
        .FILT_CYC (CE_FILT_CYC)
    ) u_ce_filt (
        .clk_in  (clk_in),
        .rstn_in (rstn_in),
        .aux     (aux.filt)
    );

    assign aux.run        = !st_ff.stopped;
    assign aux.period_sel = st_ff.period_sel;
    assign aux.ce_raw     = ce_pin_in;

    // ==========================================================================
    // Event decode
    logic [3:0]  pending;
    logic [3:0]  grant;
    logic [13:0] grant_vec;
    logic        carry_evt;
    logic        accept;
    logic        halt_exec;
    logic        stop_exec;
    logic [3:0]  wake_op;
    logic        wake;
    logic        ce_reset_now;
    logic        apb_acc;
    logic        apb_wr;
    logic        mapped;

    assign carry_evt = aux.carry_evt && !st_ff.stopped;
    assign pending   = irq_in & st_ff.permit;

    // Lowest index wins, so the pin is served before the timer
    always_comb begin
        grant     = 4'h0;
        grant_vec = hspc_pkg::VEC_RESET;
        for (int i = hspc_pkg::NUM_SRC - 1; i >= 0; i--) begin
            if (pending[i]) begin
                grant = 4'(1 << i);
                unique case (i)
                    hspc_pkg::SRC_PIN:    grant_vec = hspc_pkg::VEC_PIN;
                    hspc_pkg::SRC_TIMER:  grant_vec = hspc_pkg::VEC_TIMER;
                    hspc_pkg::SRC_VSYNC:  grant_vec = hspc_pkg::VEC_VSYNC;
                    default:              grant_vec = hspc_pkg::VEC_SERIAL;
                endcase
            end
        end
    end

    // Chip enable reset waits for a carry tick unless the core is stopped
    assign ce_reset_now = st_ff.stopped ? aux.ce_rise
                                        : ((st_ff.ce_pend || aux.ce_rise) && carry_evt);

    assign accept = st_ff.gie && !st_ff.in_service && !st_ff.stopped
                    && (st_ff.halted || boundary_in) && (|pending) && !ce_reset_now;

    assign halt_exec = instr_valid_in && instr_halt_in && !st_ff.halted && !st_ff.stopped;
    assign stop_exec = instr_valid_in && instr_stop_in && !st_ff.halted && !st_ff.stopped;

    // A new halt judges its own operand in the same cycle
    assign wake_op = halt_exec ? operand_in : st_ff.hop;
    assign wake    = (wake_op[hspc_pkg::HALT_KEY_BIT] && (|key_entry_pins_in))
                     || (wake_op[hspc_pkg::HALT_TMR_BIT] && carry_evt)
                     || (wake_op[hspc_pkg::HALT_INT_BIT] && accept);

    assign apb_acc = psel_in && penable_in;
    assign mapped  = (paddr_in == hspc_pkg::ADDR_CTRL) || (paddr_in == hspc_pkg::ADDR_PERMIT)
                     || (paddr_in == hspc_pkg::ADDR_STATUS) || (paddr_in == hspc_pkg::ADDR_CARRY);
    assign apb_wr  = apb_acc && pwrite_in && mapped;

    // ==========================================================================
    // Next state
    always_comb begin
        nxt_st = st_ff;
        nxt_st.ack       = 4'h0;
        nxt_st.vec_valid = 1'b0;
        nxt_st.nop       = 1'b0;
        nxt_st.core_rst  = 1'b0;

        // Read data captured in setup so the access phase needs no wait
        if (psel_in && !penable_in && !pwrite_in) begin
            nxt_st.prdata = 32'h0;
            unique case (paddr_in)
                hspc_pkg::ADDR_CTRL: begin
                    nxt_st.prdata[hspc_pkg::CTRL_PERIOD_BIT] = st_ff.period_sel;
                    nxt_st.prdata[hspc_pkg::CTRL_GIE_BIT]    = st_ff.gie;
                end
                hspc_pkg::ADDR_PERMIT: nxt_st.prdata[3:0] = st_ff.permit;
                hspc_pkg::ADDR_STATUS: begin
                    nxt_st.prdata[hspc_pkg::ST_HALTED_BIT]  = st_ff.halted;
                    nxt_st.prdata[hspc_pkg::ST_STOPPED_BIT] = st_ff.stopped;
                    nxt_st.prdata[hspc_pkg::ST_CE_BIT]      = aux.ce_level;
                    nxt_st.prdata[hspc_pkg::ST_CEPEND_BIT]  = st_ff.ce_pend;
                    nxt_st.prdata[hspc_pkg::ST_PFD_BIT]     = st_ff.pfd_en;
                    nxt_st.prdata[hspc_pkg::ST_INSVC_BIT]   = st_ff.in_service;
                end
                hspc_pkg::ADDR_CARRY: nxt_st.prdata[hspc_pkg::CARRY_BIT] = st_ff.carry_flag;
                default: nxt_st.prdata = 32'h0;
            endcase
        end

        if (por_in || ce_reset_now) begin
            // Either reset ends halt and stop and restarts at the reset vector
            nxt_st           = ST_RST;
            nxt_st.prdata    = st_ff.prdata;
            nxt_st.pfd_en    = por_in ? 1'b1 : st_ff.pfd_en;
            nxt_st.core_rst  = 1'b1;
            nxt_st.vec_valid = 1'b1;
            nxt_st.vec       = hspc_pkg::VEC_RESET;
        end else begin
            if (aux.ce_rise) begin
                nxt_st.ce_pend = 1'b1;
            end else if (!aux.ce_level) begin
                nxt_st.ce_pend = 1'b0;
            end

            if (apb_wr) begin
                unique case (paddr_in)
                    hspc_pkg::ADDR_CTRL: begin
                        nxt_st.period_sel = pwdata_in[hspc_pkg::CTRL_PERIOD_BIT];
                        nxt_st.gie        = pwdata_in[hspc_pkg::CTRL_GIE_BIT];
                    end
                    hspc_pkg::ADDR_PERMIT: nxt_st.permit = pwdata_in[3:0];
                    hspc_pkg::ADDR_CARRY: begin
                        if (!pwdata_in[hspc_pkg::CARRY_BIT]) begin
                            nxt_st.carry_flag = 1'b0;
                        end
                    end
                    default: nxt_st.prdata = st_ff.prdata;
                endcase
            end
            // Set after clear, so a tick in the clearing cycle survives
            if (carry_evt) begin
                nxt_st.carry_flag = 1'b1;
            end
            if (global_interrupt_enable_instr_in) begin
                nxt_st.gie = 1'b1;
            end
            if (return_from_interrupt_in) begin
                nxt_st.in_service = 1'b0;
            end

            if (accept) begin
                nxt_st.ack        = grant;
                nxt_st.gie        = 1'b0;
                nxt_st.in_service = 1'b1;
                nxt_st.vec_valid  = 1'b1;
                nxt_st.vec        = grant_vec;
            end

            if (halt_exec && !wake) begin
                nxt_st.halted = 1'b1;
                nxt_st.hop    = operand_in;
            end else if (st_ff.halted && wake) begin
                nxt_st.halted = 1'b0;
            end

            if (stop_exec) begin
                if (!aux.ce_level) begin
                    // Period select, global enable, permits and carry flag return to reset values; detector turns off
                    nxt_st.stopped    = 1'b1;
                    nxt_st.pfd_en     = 1'b0;
                    nxt_st.period_sel = 1'b0;
                    nxt_st.gie        = 1'b0;
                    nxt_st.permit     = hspc_pkg::PERMIT_RST;
                    nxt_st.carry_flag = 1'b0;
                    nxt_st.vec_valid  = 1'b1;
                    nxt_st.vec        = hspc_pkg::VEC_RESET;
                end else begin
                    nxt_st.nop = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st_ff <= ST_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ==========================================================================
    // Outputs
    assign prdata_out       = st_ff.prdata;
    assign pready_out       = 1'b1;
    assign pslverr_out      = apb_acc && !mapped;
    assign halted_out       = st_ff.halted;
    assign stopped_out      = st_ff.stopped;
    assign osc_enable_out   = !st_ff.stopped;
    assign pfd_enable_out   = st_ff.pfd_en && !st_ff.stopped;
    assign stop_nop_out     = st_ff.nop;
    assign int_ack_out      = st_ff.ack;
    assign vector_valid_out = st_ff.vec_valid;
    assign vector_addr_out  = st_ff.vec;
    assign core_reset_out   = st_ff.core_rst;

    // ==========================================================================
    // Checks
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rstn_in);

    a_timer_wake_halt: assert property (
        st_ff.halted && st_ff.hop[hspc_pkg::HALT_TMR_BIT] && carry_evt |=> !halted_out)
        else $error("timer carry did not end halt");

    a_accept_gated: assert property (
        (int_ack_out != 4'h0) |-> $past(st_ff.gie) && ($past(irq_in & st_ff.permit) != 4'h0))
        else $error("interrupt taken without enable or permit");

    a_no_enable_hold: assert property (
        st_ff.halted && st_ff.hop == hspc_pkg::HALT_OP_INT && !st_ff.gie
        && !por_in && !aux.ce_rise && !st_ff.ce_pend |=> halted_out)
        else $error("halt left with interrupts disabled");

    a_pin_first: assert property (
        accept && pending[hspc_pkg::SRC_PIN]
        |=> int_ack_out == 4'h1 && vector_addr_out == hspc_pkg::VEC_PIN && vector_valid_out)
        else $error("pin interrupt not served first");

    a_stop_as_nop: assert property (
        stop_exec && aux.ce_level && !ce_reset_now && !por_in
        |=> stop_nop_out && !stopped_out ##1 !stop_nop_out)
        else $error("stop with chip enable high not a no-op");

    a_pfd_off_stop: assert property (
        stopped_out |-> !pfd_enable_out && !osc_enable_out)
        else $error("detector or oscillator on during stop");

    a_ce_ends_stop: assert property (
        st_ff.stopped && aux.ce_rise |=> !stopped_out && core_reset_out
        && vector_addr_out == hspc_pkg::VEC_RESET)
        else $error("chip enable rise did not end stop");

    a_key_wake_halt: assert property (
        st_ff.halted && st_ff.hop[hspc_pkg::HALT_KEY_BIT] && (|key_entry_pins_in) |=> !halted_out)
        else $error("key entry did not end halt");

    a_halt_same_wake: assert property (
        halt_exec && wake |=> !halted_out)
        else $error("wake lost with halt instruction");
endmodule // hspc_top
`default_nettype wire

// ===== tb/hspc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module hspc_host_model (
    input  wire logic clk_in,
    output logic      ce_out,
    output logic      por_out
);
    // ==========================================================================
    // Chip-enable pin and supply monitor
    initial begin
        ce_out  = 1'h0;
        por_out = 1'h0;
    end
    // Pin held past the noise filter, else the level is never seen
    task automatic set_ce(input logic v, input int hold);
        @(posedge clk_in);
        ce_out <= v;
        repeat (hold) @(posedge clk_in);
    endtask
    // Supply dip and recovery, seen as one event
    task automatic power_on();
        @(posedge clk_in);
        por_out <= 1'h1;
        @(posedge clk_in);
        por_out <= 1'h0;
    endtask
endmodule // hspc_host_model
`default_nettype wire

// ===== tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    // ==========================================================================
    // Signals
    localparam int SHORT = 20;
    localparam int LONG  = 40;
    logic        clk, rstn, psel, pen, pwr, rdy, slv, iv, ihl, ist, bnd, gie, ret;
    logic        halted, stopped, osc, pfd, nop, vv, crst, ce, por, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  op, irq, key, ack;
    logic [13:0] vec;
    int          num_errors = 0;
    int          tests_run  = 0;
    int          n;
    wire  [2:0]  mon = {crst, vv, halted};
    // ==========================================================================
    // Design and far side
    hspc_top #(.CARRY_SHORT_CYC(SHORT), .CARRY_LONG_CYC(LONG), .CE_FILT_CYC(4)) DUT (
        .clk_in(clk), .rstn_in(rstn), .paddr_in(paddr), .psel_in(psel),
        .penable_in(pen), .pwrite_in(pwr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(rdy), .pslverr_out(slv), .instr_valid_in(iv), .instr_halt_in(ihl),
        .instr_stop_in(ist), .operand_in(op), .boundary_in(bnd),
        .global_interrupt_enable_instr_in(gie), .return_from_interrupt_in(ret),
        .irq_in(irq), .key_entry_pins_in(key), .ce_pin_in(ce), .por_in(por),
        .halted_out(halted), .stopped_out(stopped), .osc_enable_out(osc),
        .pfd_enable_out(pfd), .stop_nop_out(nop), .int_ack_out(ack),
        .vector_valid_out(vv), .vector_addr_out(vec), .core_reset_out(crst));
    hspc_host_model HOST (.clk_in(clk), .ce_out(ce), .por_out(por));
    initial begin
        clk = 1'h0;
        forever #50 clk = ~clk;
    end
    // ==========================================================================
    // Shared tasks
    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
        end
    endtask
    // Looks after each edge has settled, so one-cycle pulses are not missed
    task automatic wait_on(input int b, input logic v);
        for (n = 0; n < 300; n++) begin
            #1;
            if (mon[b] === v) break;
            @(posedge clk);
        end
        // A wait that runs out is a mismatch, never a silent pass
        if (n == 300) begin
            num_errors++;
            conclude();
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        {psel, pen, pwr, paddr, pwdata} <= {2'h2, w, a, d};
        @(posedge clk) pen <= 1'h1;
        for (i = 0; i < 50; i++) begin
            @(posedge clk);
            if (rdy === 1'h1) break;
        end
        rd = prdata;
        err = slv;
        {psel, pen} <= 2'h0;
        if (i == 50) begin
            num_errors++;
            conclude();
        end
    endtask
    task automatic instr(input logic h, input logic s, input logic [3:0] o);
        @(posedge clk) {iv, ihl, ist, op} <= {1'h1, h, s, o};
        @(posedge clk) iv <= 1'h0;
        #1;
    endtask
    task automatic pulse_irq(input logic [3:0] r);
        @(posedge clk) {irq, ret} <= {r, 1'h1};
        @(posedge clk) {ret, gie} <= 2'h1;
        @(posedge clk) gie <= 1'h0;
        wait_on(1, 1'h1);
    endtask
    // ==========================================================================
    // Scenarios
    task automatic t_timer();
        for (int p = 1; p >= 0; p--) begin
            apb(1'h1, hspc_pkg::ADDR_CTRL, 32'(p));
            instr(1'h1, 1'h0, hspc_pkg::HALT_OP_TIMER);
            wait_on(0, 1'h0);
            instr(1'h1, 1'h0, hspc_pkg::HALT_OP_TIMER);
            chk("halted", 32'h1, halted);
            wait_on(0, 1'h0);
            chk("period", 32'h1, 32'(p ? n <= SHORT : n > SHORT && n <= LONG));
        end
        apb(1'h0, hspc_pkg::ADDR_CARRY, 32'h0);
        chk("carry", 32'h1, rd & 32'h1);
        apb(1'h0, 12'h010, 32'h0);
        chk("slverr", 32'h1, err);
        chk("unmapped rd", 32'h0, rd);
        $display("timer wake done");
    endtask
    task automatic t_key();
        instr(1'h1, 1'h0, hspc_pkg::HALT_OP_KEY);
        @(posedge clk) key <= 4'h4;
        wait_on(0, 1'h0);
        chk("key wake", 32'h1, 32'(n < 4));
        @(posedge clk) key <= 4'h0;
        $display("key wake done");
    endtask
    task automatic t_irq();
        apb(1'h1, hspc_pkg::ADDR_PERMIT, 32'h3);
        @(posedge clk) irq <= 4'h1;
        instr(1'h1, 1'h0, hspc_pkg::HALT_OP_INT);
        repeat (10) @(posedge clk);
        chk("no enable", 32'h1, {vv, halted});
        pulse_irq(4'h1);
        chk("vector", 32'h4, vec);
        @(posedge clk) irq <= 4'h0;
        #1;
        chk("halted", 32'h0, halted);
        $display("interrupt wake done");
    endtask
    task automatic t_prio();
        logic [3:0]  rq[4] = '{4'h3, 4'h2, 4'h4, 4'h8};
        logic [13:0] vx[4] = '{14'h0004, 14'h0003, 14'h0002, 14'h0001};
        apb(1'h1, hspc_pkg::ADDR_PERMIT, 32'hF);
        @(posedge clk) bnd <= 1'h1;
        for (int k = 0; k < 4; k++) begin
            pulse_irq(rq[k]);
            chk("vector", vx[k], vec);
            chk("ack", 32'(1 << (vx[k] == 14'h4 ? 0 : 4 - vx[k])), ack);
        end
        @(posedge clk) {irq, bnd, ret} <= 6'h1;
        @(posedge clk) ret <= 1'h0;
        $display("priority done");
    endtask
    task automatic t_stop();
        instr(1'h0, 1'h1, hspc_pkg::STOP_OP);
        chk("stop", 32'h4, {stopped, osc, pfd});
        HOST.set_ce(1'h1, 0);
        wait_on(2, 1'h1);
        chk("wake", 32'h1, {stopped, osc});
        chk("vector", 32'h0, vec);
        HOST.power_on();
        repeat (2) @(posedge clk);
        #1;
        chk("pfd", 32'h1, pfd);
        instr(1'h0, 1'h1, hspc_pkg::STOP_OP);
        chk("nop", 32'h1, {stopped, nop});
        HOST.set_ce(1'h0, 8);
        HOST.set_ce(1'h1, 0);
        wait_on(2, 1'h1);
        $display("clock stop done");
    endtask
    initial begin
        {psel, pen, pwr, iv, ihl, ist, bnd, gie, ret, rstn} = '0;
        {paddr, pwdata, op, irq, key} = '0;
        repeat (5) @(posedge clk);
        rstn <= 1'h1;
        t_timer();
        t_key();
        t_irq();
        t_prio();
        t_stop();
        conclude();
    end
endmodule // tb_top
`default_nettype wire
